// ==== fpec_defines.vh ====
// Constants shared by the flash protection and erase controller.
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH

// Operation kinds.
`define FPEC_KIND_PROG   2'h0
`define FPEC_KIND_PAGE   2'h1
`define FPEC_KIND_MOD    2'h2

// Block codes: two program main blocks and the data main block.
`define FPEC_BLK_P0      2'h0
`define FPEC_BLK_P1      2'h1
`define FPEC_BLK_DAT     2'h2

// CPU address decode: addr[23:17] for program blocks, addr[23:13] for data.
`define FPEC_P0_HI       7'h00
`define FPEC_P1_HI       7'h01
`define FPEC_DAT_HI      11'h070

// Information block word index of the protection word (byte address 0FEh).
`define FPEC_PROT_IDX    8'h7F
// Word index ranges inside the shared information array.
`define FPEC_INFO_WORDS  192
`define FPEC_INFO1_BASE  64
`define FPEC_INFO2_BASE  128

// Protection word field positions.
`define FPEC_WP_MSB      15
`define FPEC_WP_LSB      13
`define FPEC_RP_MSB      12
`define FPEC_RP_LSB      10
`define FPEC_BOOT_MSB    3
`define FPEC_BOOT_LSB    1
`define FPEC_BOOT_NONE   3'h7

// Reset value of the captured protection word: fully protected until loaded.
`define FPEC_PROT_RST    16'h0000
`define FPEC_ERASED      16'hFFFF
`define FPEC_WEN_RST     16'h0000

// Packed operation record fields.
`define FPEC_OP_W        45
`define FPEC_OP_KIND     44:43
`define FPEC_OP_INFO     42
`define FPEC_OP_BLK      41:40
`define FPEC_OP_ADDR     39:16
`define FPEC_OP_DATA     15:0

// Default operation durations in core clock cycles.
`define FPEC_PROG_CYC    16'h0010
`define FPEC_ERASE_CYC   16'h0040

`endif

// ==== fpec_ctrl.v ====
// Flash section protection, global protection and erase/program sequencer.
//
// Behaviour
// R1 - Reset clears all section write enables.
// R2 - Program blocks: sixteen 8K sections each.
// R3 - Data block: sixteen 512-byte sections gated.
// R4 - Bit 0 gates the lowest section.
// R5 - Write-protect majority zero blocks CPU writes.
// R6 - Read-protect majority zero blocks external reads.
// R7 - Info blocks reached via address/data registers.
// R8 - Info block zero is read-only.
// R9 - Protection word writable, effective next reset.
// R10 - Info block erase also erases main.
// R11 - Data info block writable unless protected.
// R12 - Erase sets ones, programming clears bits.
// R13 - Pipelined programming accepts while not full.
// R14 - Read permits follow program/data busy.
// R15 - Software reads info via aligned address.
// R16 - Page erase needs enable, never boot.
// R17 - Software page erase sequence with error check.
// R18 - Module erase needs all sections, no boot.
// R19 - Info erase via data write; no page.
// R20 - Software avoids program flash self-modification.
// R21 - Busy until done; error on fail/refusal.
`timescale 1ns/1ns
`include "fpec_defines.vh"

module fpec_ctrl #(
  parameter [15:0] PROG_CYCLES  = `FPEC_PROG_CYC,
  parameter [15:0] ERASE_CYCLES = `FPEC_ERASE_CYC
) (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        wen_wr_i,
  input  wire [1:0]  wen_sel_i,
  input  wire [15:0] wen_data_i,
  input  wire        prog_program_i,
  input  wire        prog_page_erase_i,
  input  wire        prog_module_erase_i,
  input  wire        data_program_i,
  input  wire        data_page_erase_i,
  input  wire        data_module_erase_i,
  input  wire        prog_err_clr_i,
  input  wire        data_err_clr_i,
  input  wire        cpu_wr_i,
  input  wire [23:0] cpu_addr_i,
  input  wire [15:0] cpu_wdata_i,
  input  wire        ia_wr_i,
  input  wire        ia_mem_i,
  input  wire [7:0]  ia_addr_i,
  input  wire        id_wr_i,
  input  wire        id_rd_i,
  input  wire        id_mem_i,
  input  wire [15:0] id_wdata_i,
  input  wire        arr_fail_i,
  output reg         prog_busy_o,
  output reg         data_busy_o,
  output reg         pipeline_full_o,
  output reg         prog_read_ok_o,
  output reg         data_read_ok_o,
  output reg         prog_erase_error_o,
  output reg         data_erase_error_o,
  output reg         prog_prog_error_o,
  output reg         data_prog_error_o,
  output reg         global_write_protect_o,
  output reg         ext_read_block_o,
  output reg  [15:0] info_rdata_o,
  output reg         arr_op_o,
  output reg  [1:0]  arr_kind_o,
  output reg  [1:0]  arr_blk_o,
  output reg  [23:0] arr_addr_o,
  output reg  [15:0] arr_data_o
);

  reg [15:0]            prog_blk0_write_enable;
  reg [15:0]            prog_blk1_write_enable;
  reg [15:0]            data_flash_write_enable;
  reg [7:0]             prog_info_addr_reg;
  reg [7:0]             data_info_addr_reg;
  reg [15:0]            prot_word;
  reg                   prot_loaded;
  reg [15:0]            info_mem [0:`FPEC_INFO_WORDS-1];
  reg                   act_v;
  reg [`FPEC_OP_W-1:0]  act;
  reg                   act_fail;
  reg [15:0]            cnt;
  reg                   pend_v;
  reg [`FPEC_OP_W-1:0]  pend;
  reg                   next_act_v;
  reg [`FPEC_OP_W-1:0]  next_act;
  reg                   next_fail;
  reg [15:0]            next_cnt;
  reg                   next_pend_v;
  reg [`FPEC_OP_W-1:0]  next_pend;
  reg                   load;
  reg                   req_v;
  reg                   req_refuse;
  reg [`FPEC_OP_W-1:0]  req_op;
  reg [1:0]             r_kind;
  reg [1:0]             r_blk;
  reg                   r_mem;
  reg [15:0]            r_wen;
  reg [3:0]             r_sec;
  reg [7:0]             ib_addr;
  integer               i;
  integer               j;

  // Majority of three bits set.
  function maj3;
    input [2:0] b;
    begin
      maj3 = (b[0] & b[1]) | (b[0] & b[2]) | (b[1] & b[2]);
    end
  endfunction

  // Mode selected by the control bits: module erase beats page erase beats program.
  function [2:0] mode_of;
    input pe;
    input page_erase_bit;
    input module_erase_bit;
    begin
      if (module_erase_bit)
        mode_of = {1'b1, `FPEC_KIND_MOD};
      else if (page_erase_bit)
        mode_of = {1'b1, `FPEC_KIND_PAGE};
      else if (pe)
        mode_of = {1'b1, `FPEC_KIND_PROG};
      else
        mode_of = 3'h0;
    end
  endfunction

  // Word index into the shared information array.
  function [7:0] info_idx;
    input       mem;
    input [7:0] addr;
    begin
      info_idx = mem ? {2'b10, addr[6:1]} : {1'b0, addr[7:1]};
    end
  endfunction

  wire       wp       = ~maj3(prot_word[`FPEC_WP_MSB:`FPEC_WP_LSB]); // see R5
  wire       rp       = ~maj3(prot_word[`FPEC_RP_MSB:`FPEC_RP_LSB]); // see R6
  wire [2:0] boot_fld = prot_word[`FPEC_BOOT_MSB:`FPEC_BOOT_LSB];
  wire       boot_def = boot_fld != `FPEC_BOOT_NONE;
  // Inverted field counts 1 KiB blocks of boot area.
  wire [16:0] boot_end = {4'h0, ~boot_fld, 10'h000};
  wire        done     = act_v && (cnt == 16'h0000);
  wire        act_mem  = act[`FPEC_OP_BLK] == `FPEC_BLK_DAT;
  wire        act_prog = act[`FPEC_OP_KIND] == `FPEC_KIND_PROG;
  wire [2:0]  pmode    = mode_of(prog_program_i, prog_page_erase_i, prog_module_erase_i);
  wire [2:0]  dmode    = mode_of(data_program_i, data_page_erase_i, data_module_erase_i);
  wire        req_ok   = req_v && !req_refuse && !pend_v; // see R13
  wire        ref_ev   = req_v && req_refuse;
  wire        ref_prog = req_op[`FPEC_OP_KIND] == `FPEC_KIND_PROG;
  wire        ref_mem  = req_op[`FPEC_OP_BLK] == `FPEC_BLK_DAT;
  wire        fin_ev   = done && act_fail;

  // Request decode and protection checks.
  always @*
  begin
    req_v      = 1'b0;
    req_refuse = 1'b0;
    r_kind     = `FPEC_KIND_PROG;
    r_blk      = `FPEC_BLK_P0;
    r_mem      = 1'b0;
    r_wen      = prog_blk0_write_enable;
    r_sec      = cpu_addr_i[16:13]; // see R2
    ib_addr    = id_mem_i ? data_info_addr_reg : prog_info_addr_reg;
    if (cpu_wr_i)
    begin
      if (cpu_addr_i[23:17] == `FPEC_P1_HI)
        r_blk = `FPEC_BLK_P1;
      else if (cpu_addr_i[23:13] == `FPEC_DAT_HI)
      begin
        r_blk = `FPEC_BLK_DAT;
        r_sec = cpu_addr_i[12:9]; // see R3
      end
      r_mem = r_blk == `FPEC_BLK_DAT;
      req_v = (cpu_addr_i[23:17] == `FPEC_P0_HI) || (cpu_addr_i[23:17] == `FPEC_P1_HI) || r_mem;
      {req_v, r_kind} = r_mem ? {req_v & dmode[2], dmode[1:0]}
                              : {req_v & pmode[2], pmode[1:0]};
      r_wen = (r_blk == `FPEC_BLK_P1) ? prog_blk1_write_enable :
              r_mem ? data_flash_write_enable : prog_blk0_write_enable;
      if (r_kind == `FPEC_KIND_MOD)
        req_refuse = wp || !(&r_wen) || (r_blk == `FPEC_BLK_P0 && boot_def); // see R18
      else
        req_refuse = wp || !r_wen[r_sec] || // see R4
                     (r_blk == `FPEC_BLK_P0 && cpu_addr_i[16:0] < boot_end); // see R16
      req_op = {r_kind, 1'b0, r_blk, cpu_addr_i, cpu_wdata_i};
    end
    else
    begin
      // Information blocks are only reached through the indirect registers.
      r_mem = id_mem_i; // see R7
      r_blk = id_mem_i ? `FPEC_BLK_DAT : (ib_addr[7] ? `FPEC_BLK_P1 : `FPEC_BLK_P0);
      {req_v, r_kind} = id_mem_i ? {id_wr_i & dmode[2], dmode[1:0]}
                                 : {id_wr_i & pmode[2], pmode[1:0]};
      r_wen = id_mem_i ? data_flash_write_enable : prog_blk1_write_enable;
      if (r_kind == `FPEC_KIND_MOD)
        req_refuse = wp || !(&r_wen); // see R19
      else if (r_kind == `FPEC_KIND_PAGE)
        req_refuse = 1'b1; // see R19
      else
        req_refuse = wp || (r_blk == `FPEC_BLK_P1 && !r_wen[0]); // see R9 see R11
      if (r_blk == `FPEC_BLK_P0)
        req_refuse = 1'b1; // see R8
      req_op = {r_kind, 1'b1, r_blk, 16'h0000, ib_addr, id_wdata_i};
    end
  end

  // Two-slot pipeline: one running operation and one waiting.
  always @*
  begin
    next_act_v  = act_v;
    next_act    = act;
    next_pend_v = pend_v;
    next_pend   = pend;
    next_cnt    = cnt;
    next_fail   = act_fail | (act_v & arr_fail_i);
    load        = 1'b0;
    if (act_v && cnt != 16'h0000)
      next_cnt = cnt - 16'h0001;
    if (!act_v || done)
    begin
      if (pend_v)
      begin
        next_act    = pend;
        next_act_v  = 1'b1;
        next_pend_v = 1'b0;
        load        = 1'b1;
      end
      else if (req_ok)
      begin
        next_act   = req_op;
        next_act_v = 1'b1;
        load       = 1'b1;
      end
      else
        next_act_v = 1'b0;
    end
    else if (req_ok)
    begin
      next_pend_v = 1'b1; // see R13
      next_pend   = req_op;
    end
    if (load)
    begin
      next_fail = 1'b0;
      next_cnt  = (next_act[`FPEC_OP_KIND] == `FPEC_KIND_PROG) ? PROG_CYCLES - 16'h0001
                                                              : ERASE_CYCLES - 16'h0001;
    end
  end

  wire n_act_mem  = next_act[`FPEC_OP_BLK] == `FPEC_BLK_DAT;
  wire n_pend_mem = next_pend[`FPEC_OP_BLK] == `FPEC_BLK_DAT;
  wire n_pbusy    = (next_act_v & ~n_act_mem) | (next_pend_v & ~n_pend_mem);
  wire n_dbusy    = (next_act_v & n_act_mem) | (next_pend_v & n_pend_mem);

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      prog_blk0_write_enable  <= `FPEC_WEN_RST; // see R1
      prog_blk1_write_enable  <= `FPEC_WEN_RST; // see R1
      data_flash_write_enable <= `FPEC_WEN_RST; // see R1
      prog_info_addr_reg      <= 8'h00;
      data_info_addr_reg      <= 8'h00;
      prot_word               <= `FPEC_PROT_RST;
      prot_loaded             <= 1'b0;
      act_v                   <= 1'b0;
      act                     <= {`FPEC_OP_W{1'b0}};
      act_fail                <= 1'b0;
      cnt                     <= 16'h0000;
      pend_v                  <= 1'b0;
      pend                    <= {`FPEC_OP_W{1'b0}};
      prog_busy_o             <= 1'b0;
      data_busy_o             <= 1'b0;
      pipeline_full_o         <= 1'b0;
      prog_read_ok_o          <= 1'b0;
      data_read_ok_o          <= 1'b0;
      prog_erase_error_o      <= 1'b0;
      data_erase_error_o      <= 1'b0;
      prog_prog_error_o       <= 1'b0;
      data_prog_error_o       <= 1'b0;
      global_write_protect_o  <= 1'b1;
      ext_read_block_o        <= 1'b1;
      arr_op_o                <= 1'b0;
      arr_kind_o              <= 2'h0;
      arr_blk_o               <= 2'h0;
      arr_addr_o              <= 24'h000000;
      arr_data_o              <= 16'h0000;
    end
    else
    begin
      if (wen_wr_i && wen_sel_i == `FPEC_BLK_P0)
        prog_blk0_write_enable <= wen_data_i;
      if (wen_wr_i && wen_sel_i == `FPEC_BLK_P1)
        prog_blk1_write_enable <= wen_data_i;
      if (wen_wr_i && wen_sel_i == `FPEC_BLK_DAT)
        data_flash_write_enable <= wen_data_i;
      if (ia_wr_i && !ia_mem_i)
        prog_info_addr_reg <= ia_addr_i;
      if (ia_wr_i && ia_mem_i)
        data_info_addr_reg <= ia_addr_i;
      // The word is sampled once after reset, so later writes only act at the next reset.
      if (!prot_loaded)
      begin
        prot_word   <= info_mem[`FPEC_PROT_IDX]; // see R9
        prot_loaded <= 1'b1;
      end
      act_v           <= next_act_v;
      act             <= next_act;
      act_fail        <= next_fail;
      cnt             <= next_cnt;
      pend_v          <= next_pend_v;
      pend            <= next_pend;
      prog_busy_o     <= n_pbusy; // see R21
      data_busy_o     <= n_dbusy; // see R21
      pipeline_full_o <= next_pend_v; // see R13
      prog_read_ok_o  <= ~n_pbusy; // see R14
      data_read_ok_o  <= ~n_pbusy & ~n_dbusy; // see R14
      // A new error event wins over a clear in the same cycle.
      prog_erase_error_o <= (prog_erase_error_o & ~prog_err_clr_i) | // see R21
                            (ref_ev & ~ref_prog & ~ref_mem) | (fin_ev & ~act_prog & ~act_mem);
      data_erase_error_o <= (data_erase_error_o & ~data_err_clr_i) |
                            (ref_ev & ~ref_prog & ref_mem) | (fin_ev & ~act_prog & act_mem);
      prog_prog_error_o  <= (prog_prog_error_o & ~prog_err_clr_i) |
                            (ref_ev & ref_prog & ~ref_mem) | (fin_ev & act_prog & ~act_mem);
      data_prog_error_o  <= (data_prog_error_o & ~data_err_clr_i) |
                            (ref_ev & ref_prog & ref_mem) | (fin_ev & act_prog & act_mem);
      global_write_protect_o <= wp; // see R5
      ext_read_block_o       <= rp; // see R6
      // Main array is started when a main-array operation enters the running slot; an info
      // block erase also starts a module erase of its main block.
      arr_op_o   <= load && (!next_act[`FPEC_OP_INFO] ||
                    next_act[`FPEC_OP_KIND] == `FPEC_KIND_MOD); // see R10 see R12
      arr_kind_o <= next_act[`FPEC_OP_KIND];
      arr_blk_o  <= next_act[`FPEC_OP_BLK];
      arr_addr_o <= next_act[`FPEC_OP_ADDR];
      arr_data_o <= next_act[`FPEC_OP_DATA];
    end
  end

  // The array starts erased, as unprogrammed flash cells read all ones.
  initial
    for (j = 0; j < `FPEC_INFO_WORDS; j = j + 1)
      info_mem[j] = `FPEC_ERASED;

  // Information array: no reset, it models non-volatile content.
  always @(posedge core_clk_i)
  begin
    if (id_rd_i)
      info_rdata_o <= info_mem[info_idx(id_mem_i, id_mem_i ? data_info_addr_reg
                                                           : prog_info_addr_reg)];
    if (done && act[`FPEC_OP_INFO] && !act_fail)
    begin
      if (act_prog)
        info_mem[info_idx(act_mem, act[23:16])] <=
          info_mem[info_idx(act_mem, act[23:16])] & act[`FPEC_OP_DATA]; // see R12
      else
        for (i = 0; i < `FPEC_INFO_WORDS; i = i + 1)
          if (i[7:6] == act[`FPEC_OP_BLK]) // Index bits 7:6 equal the block code.
            info_mem[i] <= `FPEC_ERASED; // see R12
    end
  end

endmodule // fpec_ctrl

// ==== fpec_ctrl_assertions.sv ====
// Port-level checks for the flash protection and erase controller.
`timescale 1ns/1ns
module fpec_ctrl_assertions #(
  parameter [15:0] PROG_CYCLES  = 16'h0010,
  parameter [15:0] ERASE_CYCLES = 16'h0040
) (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire        cpu_wr_i,
  input wire [23:0] cpu_addr_i,
  input wire        id_wr_i,
  input wire        id_mem_i,
  input wire        ia_wr_i,
  input wire        ia_mem_i,
  input wire [7:0]  ia_addr_i,
  input wire        prog_program_i,
  input wire        prog_page_erase_i,
  input wire        prog_module_erase_i,
  input wire        prog_busy_o,
  input wire        data_busy_o,
  input wire        pipeline_full_o,
  input wire        prog_read_ok_o,
  input wire        data_read_ok_o,
  input wire        prog_prog_error_o,
  input wire        prog_erase_error_o,
  input wire        global_write_protect_o,
  input wire        ext_read_block_o,
  input wire        arr_op_o,
  input wire [1:0]  arr_kind_o
);
  reg  [7:0] ia_last;
  wire       p_prog = prog_program_i && !prog_page_erase_i && !prog_module_erase_i;

  // Shadow of the program-side address register, which is not visible at the ports.
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      ia_last <= 8'h00;
    else if (ia_wr_i && !ia_mem_i)
      ia_last <= ia_addr_i;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_rst_clear: assert property ($past(rst_i) |-> !prog_busy_o && !pipeline_full_o && !arr_op_o)
    else $error("state not clear after reset");
  a_op_busy: assert property (arr_op_o |-> prog_busy_o || data_busy_o)
    else $error("array op without busy");
  a_op_pulse: assert property (arr_op_o |=> !arr_op_o)
    else $error("array op longer than one cycle");
  a_full_busy: assert property (pipeline_full_o |-> prog_busy_o || data_busy_o)
    else $error("full while idle");
  a_prot_stable: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    && !$past(rst_i, 4) |-> $stable(global_write_protect_o) && $stable(ext_read_block_o))
    else $error("protection changed without reset");
  a_prot_refuse: assert property (global_write_protect_o && cpu_wr_i && p_prog
    && cpu_addr_i[23:18] == 6'h00 |=> prog_prog_error_o)
    else $error("protected write not flagged");
  a_prot_noop: assert property (global_write_protect_o && (cpu_wr_i || id_wr_i) |=> !arr_op_o)
    else $error("protected write reached array");
  a_info0_ro: assert property (id_wr_i && !cpu_wr_i && !id_mem_i && !ia_last[7] && p_prog
    |=> prog_prog_error_o)
    else $error("info block zero write not refused");
  a_read_prog: assert property (prog_busy_o |-> !prog_read_ok_o && !data_read_ok_o)
    else $error("read allowed while program busy");
  a_read_data: assert property (data_busy_o |-> !data_read_ok_o)
    else $error("data read allowed while data busy");

  c_full: cover property (pipeline_full_o);
  c_mod: cover property (arr_op_o && arr_kind_o == 2'h2);
  c_err: cover property ($rose(prog_erase_error_o));
endmodule // fpec_ctrl_assertions

// ==== fpec_ctrl_tb_top.sv ====
// Self-checking bench for the flash protection and erase controller.
`timescale 1ns/1ns
module fpec_ctrl_tb_top;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, arr_fail_i = 1'b0;
  logic        wen_wr_i = 1'b0, cpu_wr_i = 1'b0, ia_wr_i = 1'b0, ia_mem_i = 1'b0;
  logic        id_wr_i = 1'b0, id_rd_i = 1'b0, id_mem_i = 1'b0;
  logic        prog_program_i = 1'b0, prog_page_erase_i = 1'b0, prog_module_erase_i = 1'b0;
  logic        data_program_i = 1'b0, data_page_erase_i = 1'b0, data_module_erase_i = 1'b0;
  logic        prog_err_clr_i = 1'b0, data_err_clr_i = 1'b0;
  logic [1:0]  wen_sel_i = 2'h0;
  logic [7:0]  ia_addr_i = 8'h00;
  logic [15:0] wen_data_i = 16'h0000, cpu_wdata_i = 16'h0000, id_wdata_i = 16'h0000;
  logic [23:0] cpu_addr_i = 24'h000000;
  wire         prog_busy_o, data_busy_o, pipeline_full_o, prog_read_ok_o, data_read_ok_o;
  wire         prog_erase_error_o, data_erase_error_o, prog_prog_error_o, data_prog_error_o;
  wire         global_write_protect_o, ext_read_block_o, arr_op_o;
  wire [1:0]   arr_kind_o, arr_blk_o;
  wire [15:0]  info_rdata_o, arr_data_o;
  wire [23:0]  arr_addr_o;
  wire [3:0]   errs = {prog_prog_error_o, prog_erase_error_o, data_prog_error_o, data_erase_error_o};
  logic [15:0] q;
  int          fails = 0, checks = 0;

  // Short operation times keep every wait within a few cycles.
  fpec_ctrl #(.PROG_CYCLES(16'h0004), .ERASE_CYCLES(16'h0006)) u_dut (.*);

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic maj0(input logic [2:0] b);
    return (!b[0] && !b[1]) || (!b[0] && !b[2]) || (!b[1] && !b[2]);
  endfunction

  task automatic idle();
    int n;
    n = 0;
    while ((prog_busy_o !== 1'b0 || data_busy_o !== 1'b0) && n < 300)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 300)
    begin
      fails++;
      conclude();
    end
  endtask

  // Expected e is {op, kind, block, errors}; f is the error set once the op is over.
  task automatic go(input logic [8:0] e, input logic [3:0] f);
    if (e[8])
      chk({arr_op_o, arr_kind_o, arr_blk_o, errs}, e);
    else
      chk({arr_op_o, errs}, {e[8], e[3:0]});
    idle();
    @(negedge core_clk_i);
    chk(errs, f);
    prog_err_clr_i = 1'b1;
    data_err_clr_i = 1'b1;
    @(negedge core_clk_i);
    prog_err_clr_i = 1'b0;
    data_err_clr_i = 1'b0;
  endtask

  task automatic md(input logic m, input logic [2:0] v);
    {prog_module_erase_i, prog_page_erase_i, prog_program_i} = m ? 3'h0 : v;
    {data_module_erase_i, data_page_erase_i, data_program_i} = m ? v : 3'h0;
  endtask

  task automatic wen(input logic [1:0] s, input logic [15:0] d);
    wen_sel_i = s;
    wen_data_i = d;
    wen_wr_i = 1'b1;
    @(negedge core_clk_i);
    wen_wr_i = 1'b0;
  endtask

  task automatic cpu(input logic [23:0] a);
    cpu_addr_i = a;
    cpu_wr_i = 1'b1;
    @(negedge core_clk_i);
    cpu_wr_i = 1'b0;
  endtask

  task automatic ia(input logic m, input logic [7:0] a);
    ia_mem_i = m;
    ia_addr_i = a;
    ia_wr_i = 1'b1;
    @(negedge core_clk_i);
    ia_wr_i = 1'b0;
  endtask

  task automatic id(input logic m, input logic [15:0] d);
    id_mem_i = m;
    id_wdata_i = d;
    id_wr_i = 1'b1;
    @(negedge core_clk_i);
    id_wr_i = 1'b0;
  endtask

  task automatic rd(input logic m, input logic [7:0] a, output logic [15:0] d);
    ia(m, a);
    id_mem_i = m;
    id_rd_i = 1'b1;
    @(negedge core_clk_i);
    id_rd_i = 1'b0;
    @(negedge core_clk_i);
    d = info_rdata_o;
  endtask

  task automatic s_reset();
    chk({prog_busy_o, data_busy_o, pipeline_full_o, errs}, 7'h00);
    rd(1'b0, 8'hFE, q);
    chk(global_write_protect_o, maj0(q[15:13]));
    chk(ext_read_block_o, maj0(q[12:10]));
  endtask

  task automatic s_sect();
    md(1'b0, 3'h1);
    cpu(24'h000000);
    go(9'h008, 4'h8);
    wen(2'h1, 16'h0008);
    cpu(24'h026000);
    go(9'h110, 4'h0);
    cpu(24'h025FFE);
    go(9'h008, 4'h8);
    wen(2'h0, 16'h0001);
    cpu(24'h001FFE);
    go(9'h100, 4'h0);
    md(1'b1, 3'h1);
    wen(2'h2, 16'h8000);
    cpu(24'h0E1E00);
    go(9'h120, 4'h0);
    chk(arr_addr_o, 24'h0E1E00);
    cpu(24'h0E1DFE);
    go(9'h002, 4'h2);
  endtask

  task automatic s_pipe();
    int n;
    md(1'b0, 3'h1);
    cpu_addr_i = 24'h026000;
    cpu_wr_i = 1'b1;
    @(negedge core_clk_i);
    @(negedge core_clk_i);
    cpu_wr_i = 1'b0;
    chk({pipeline_full_o, prog_busy_o, prog_read_ok_o, data_read_ok_o}, 4'hC);
    n = 0;
    while (arr_op_o !== 1'b1 && n < 50)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk({arr_op_o, prog_busy_o}, 2'h3);
    idle();
    chk({pipeline_full_o, errs}, 5'h00);
  endtask

  task automatic s_erase();
    md(1'b0, 3'h2);
    wen(2'h0, 16'h0002);
    cpu(24'h002400);
    go(9'h140, 4'h0);
    cpu(24'h000400);
    go(9'h004, 4'h4);
    md(1'b0, 3'h4);
    cpu(24'h000000);
    go(9'h004, 4'h4);
    wen(2'h1, 16'hFFFF);
    cpu(24'h030000);
    go(9'h190, 4'h0);
    arr_fail_i = 1'b1;
    cpu(24'h020000);
    go(9'h190, 4'h4);
    arr_fail_i = 1'b0;
  endtask

  task automatic s_info();
    md(1'b0, 3'h1);
    ia(1'b0, 8'h10);
    id(1'b0, 16'h0000);
    go(9'h008, 4'h8);
    md(1'b0, 3'h4);
    ia(1'b0, 8'h80);
    id(1'b0, 16'h1234);
    go(9'h190, 4'h0);
    rd(1'b0, 8'h80, q);
    chk(q, 16'hFFFF);
    md(1'b0, 3'h2);
    id(1'b0, 16'h0000);
    go(9'h004, 4'h4);
    md(1'b1, 3'h4);
    wen(2'h2, 16'hFFFF);
    ia(1'b1, 8'h00);
    id(1'b1, 16'h0000);
    go(9'h1A0, 4'h0);
    md(1'b1, 3'h1);
    ia(1'b1, 8'h02);
    id(1'b1, 16'h1234);
    go(9'h000, 4'h0);
    id(1'b1, 16'hFF0F);
    go(9'h000, 4'h0);
    rd(1'b1, 8'h02, q);
    chk(q, 16'h1204);
  endtask

  // Leaves the part globally protected, so it runs last.
  task automatic s_prot();
    md(1'b0, 3'h1);
    wen(2'h1, 16'h0001);
    ia(1'b0, 8'hFE);
    id(1'b0, 16'h03FF);
    go(9'h000, 4'h0);
    chk(global_write_protect_o, 1'b0);
    rst_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk({global_write_protect_o, ext_read_block_o}, 2'h3);
    wen(2'h1, 16'hFFFF);
    cpu(24'h020000);
    go(9'h008, 4'h8);
    md(1'b1, 3'h1);
    ia(1'b1, 8'h00);
    id(1'b1, 16'h0000);
    go(9'h002, 4'h2);
  endtask

  initial
  begin
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    s_reset();
    s_sect();
    s_pipe();
    s_erase();
    s_info();
    s_prot();
    conclude();
  end
endmodule // fpec_ctrl_tb_top

bind fpec_ctrl fpec_ctrl_assertions #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .core_clk_i, .rst_i, .cpu_wr_i, .cpu_addr_i, .id_wr_i, .id_mem_i, .ia_wr_i, .ia_mem_i,
  .ia_addr_i, .prog_program_i, .prog_page_erase_i, .prog_module_erase_i, .prog_busy_o,
  .data_busy_o, .pipeline_full_o, .prog_read_ok_o, .data_read_ok_o, .prog_prog_error_o,
  .prog_erase_error_o, .global_write_protect_o, .ext_read_block_o, .arr_op_o, .arr_kind_o);
